/* prot_stage_defs.svh */
// Contract
// - Compare measured magnitude against pick-up level continuously
// - Release only past 97 percent reset threshold
// - Sample blocking input at each program cycle start
// - Unblocked pick-up raises start, begins timing
// - Blocked pick-up raises blocked, suppresses timing
// - Blocking clears start, releases like pick-up reset
// - Becoming blocked issues time-stamped event with values
// - Instant operation trips with start, no delay
// - Definite time trips after delay while picked
// - Inverse mode delay follows measured/pick-up ratio
// - Definite delay bounds inverse trip time; zero none
// - Delay type selector, definite time after reset
// - Definite delay in 5 ms steps, default 40 ms
// - Zero definite delay trips instantly
// - Curve series IEC or IEEE, default IEC
// - IEC kA/(r^B-1), IEEE k(A/(r^C-1)+B)
// - Time dial 0.01 s steps, default 0.05 s
`ifndef PROT_STAGE_DEFS_SVH
`define PROT_STAGE_DEFS_SVH

`define REF_CLK_PERIOD_NS  32'h0000_0064
`define PROG_CYCLE_US      32'h0000_1388
`define NS_PER_US          32'h0000_03E8
`define RESET_PCT          7'h61
`define FULL_PCT           7'h64
`define FIXED_DELAY_DEF    19'h0_0008
`define DIAL_DEF           12'h005
`define CONST_A_DEF        22'h00_035C
`define CONST_B_DEF        22'h00_073A
`define CONST_C_DEF        22'h00_00C8
`define LOG_FRAC_ONE       26'h000_0100
`define CONST_SCALE        32'h0000_2710
`define DIAL_PER_STEP      40'h00_0000_1388
`define EXP_INT_MAX        5'h0F

`endif

/* prot_stage_pkg.sv */
package prot_stage_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STARTED,
    ST_TRIPPED,
    ST_BLOCKED
  } stage_state_t;

  typedef struct packed {
    logic        inverse_delay_mode;
    logic        ieee_series;
    logic [18:0] fixed_delay;
    logic [11:0] dial;
    logic [21:0] const_a;
    logic [21:0] const_b;
    logic [21:0] const_c;
  } stage_cfg_t;

  typedef struct packed {
    stage_state_t state;
    stage_cfg_t   cfg;
    logic [31:0]  div;
    logic         picked;
    logic [19:0]  elapsed;
    logic         inv_ok;
    logic [19:0]  inv_delay;
    logic [31:0]  stamp;
    logic         start_out;
    logic         trip_out;
    logic         blocked_out;
    logic         event_valid;
    logic [15:0]  event_magnitude;
    logic         event_under;
    logic [31:0]  event_stamp;
  } stage_regs_t;

  typedef struct packed {
    logic        busy;
    logic [6:0]  cnt;
    logic [63:0] rem;
    logic [63:0] quo;
    logic [63:0] dsr;
    logic        done;
    logic [19:0] delay;
  } calc_regs_t;

endpackage

/* inverse_delay_calc.sv */
`timescale 1ns/1ps
`include "prot_stage_defs.svh"

module inverse_delay_calc
  import prot_stage_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Request
  input  wire logic        go,
  input  wire logic [15:0] measured_magnitude,
  input  wire logic [15:0] pickup_level,
  input  wire logic        under_mode,
  input  wire stage_cfg_t  cfg,
  // Result in program cycles
  output logic             done,
  output logic [19:0]      delay
);

  calc_regs_t s;
  calc_regs_t next_s;

  // Log2 with 8 fraction bits, linear mantissa
  function automatic logic [12:0] log2_q8(input logic [15:0] x);
    logic [3:0]  pos;
    logic [15:0] sh;
    pos = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (x[i]) begin
        pos = 4'(i);
      end
    end
    sh = x << (4'hF - pos);
    return {1'b0, pos, sh[14:7]};
  endfunction

  logic signed [13:0] lr;
  logic [39:0]        e8;
  logic [4:0]         e_int;
  logic [25:0]        den8;
  logic [63:0]        num;
  logic [64:0]        trial;

  always_comb begin
    // ratio taken in the direction that exceeds one
    if (under_mode) begin
      lr = 14'(log2_q8(pickup_level)) - 14'(log2_q8(measured_magnitude));
    end else begin
      lr = 14'(log2_q8(measured_magnitude)) - 14'(log2_q8(pickup_level));
    end
    // exponent B for IEC, C for IEEE
    e8 = (lr > 14'sh0000)
       ? 40'(40'(lr) * 40'(cfg.ieee_series ? cfg.const_c : cfg.const_b)) / 40'(`CONST_SCALE)
       : 40'h00_0000_0000;
    e_int = (e8[39:8] > 32'(`EXP_INT_MAX)) ? `EXP_INT_MAX : e8[12:8];
    den8 = ((`LOG_FRAC_ONE + 26'(e8[7:0])) << e_int) - `LOG_FRAC_ONE;
    num = 64'(cfg.dial) * 64'(cfg.const_a) * 64'(`LOG_FRAC_ONE);
    if (cfg.ieee_series) begin
      num = num + 64'(cfg.dial) * 64'(cfg.const_b) * 64'(den8);
    end
  end

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    trial       = {s.rem, s.quo[63]};
    if (go) begin
      next_s.busy = 1'b1;
      next_s.cnt  = 7'h00;
      next_s.rem  = 64'h0000_0000_0000_0000;
      next_s.quo  = num;
      next_s.dsr  = 64'(den8) * 64'(`DIAL_PER_STEP);
    end else if (s.busy) begin
      // Restoring divide, one quotient bit per clock
      next_s.quo = {s.quo[62:0], 1'b0};
      if (trial >= {1'b0, s.dsr}) begin
        next_s.rem    = 64'(trial - {1'b0, s.dsr});
        next_s.quo[0] = 1'b1;
      end else begin
        next_s.rem = trial[63:0];
      end
      next_s.cnt = s.cnt + 7'h01;
      if (s.cnt == 7'h3F) begin
        next_s.busy  = 1'b0;
        next_s.done  = 1'b1;
        // Ratio at or below one, or an overflowing quotient, gives the maximum delay
        if (s.dsr == 64'h0000_0000_0000_0000 || next_s.quo[63:20] != 44'h000_0000_0000) begin
          next_s.delay = 20'hF_FFFF;
        end else begin
          next_s.delay = next_s.quo[19:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done  = s.done;
  assign delay = s.delay;

endmodule // inverse_delay_calc

/* protection_stage_timing.sv */
`timescale 1ns/1ps
`include "prot_stage_defs.svh"

module protection_stage_timing
  import prot_stage_pkg::*;
#(
  parameter int PROG_CYCLE_CLKS =
    `PROG_CYCLE_US * `NS_PER_US / `REF_CLK_PERIOD_NS
)(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Measurement chain and blocking matrix
  input  wire logic [15:0] measured_magnitude,
  input  wire logic [15:0] pickup_level,
  input  wire logic        under_mode,
  input  wire logic        block_in,
  // Settings, taken on settings_load
  input  wire logic        settings_load,
  input  wire logic        set_inverse_delay_mode,
  input  wire logic        set_ieee_series,
  input  wire logic [18:0] set_fixed_delay,
  input  wire logic [11:0] set_dial,
  input  wire logic [21:0] set_const_a,
  input  wire logic [21:0] set_const_b,
  input  wire logic [21:0] set_const_c,
  // Output matrix
  output logic             start_out,
  output logic             trip_out,
  output logic             blocked_out,
  output logic             inverse_delay_mode,
  output logic             program_tick,
  // Event log
  output logic             event_valid,
  output logic [15:0]      event_magnitude,
  output logic             event_under,
  output logic [31:0]      event_stamp
);

  stage_regs_t s;
  stage_regs_t next_s;

  logic        tick;
  logic        tick_q;
  logic        blk;
  logic        picked_now;
  logic [22:0] rel_thr;
  logic [19:0] elapsed_inc;
  logic [19:0] eff_delay;
  logic        reached;
  logic        calc_go;
  logic        calc_done;
  logic [19:0] calc_delay;

  // Percentage of a level, scaled by num/den
  function automatic logic [22:0] scale_pct(input logic [15:0] lvl,
                                            input logic [6:0]  mul,
                                            input logic [6:0]  dvs);
    return 23'((23'(lvl) * 23'(mul)) / 23'(dvs));
  endfunction

  assign tick = (s.div == 32'(PROG_CYCLE_CLKS - 1));

  always_comb begin
    if (under_mode) begin
      rel_thr = scale_pct(pickup_level, `FULL_PCT, `RESET_PCT);
      picked_now = s.picked ? (23'(measured_magnitude) < rel_thr)
                            : (measured_magnitude < pickup_level);
    end else begin
      rel_thr = scale_pct(pickup_level, `RESET_PCT, `FULL_PCT);
      picked_now = s.picked ? (23'(measured_magnitude) > rel_thr)
                            : (measured_magnitude > pickup_level);
    end
  end

  assign blk         = block_in;
  assign calc_go     = tick && picked_now && s.cfg.inverse_delay_mode;
  assign elapsed_inc = (s.elapsed == 20'hF_FFFF) ? s.elapsed : s.elapsed + 20'h0_0001;

  always_comb begin
    if (!s.cfg.inverse_delay_mode) begin
      eff_delay = 20'(s.cfg.fixed_delay);
      reached   = elapsed_inc >= eff_delay;
    end else begin
      eff_delay = (s.inv_delay > 20'(s.cfg.fixed_delay)) ? s.inv_delay
                                                         : 20'(s.cfg.fixed_delay);
      reached   = s.inv_ok && (elapsed_inc >= eff_delay);
    end
  end

  inverse_delay_calc u_calc (
    .ref_clk            (ref_clk),
    .sys_rst            (sys_rst),
    .go                 (calc_go),
    .measured_magnitude (measured_magnitude),
    .pickup_level       (pickup_level),
    .under_mode         (under_mode),
    .cfg                (s.cfg),
    .done               (calc_done),
    .delay              (calc_delay)
  );

  always_comb begin
    next_s             = s;
    next_s.event_valid = 1'b0;
    next_s.div         = tick ? 32'h0000_0000 : s.div + 32'h0000_0001;

    if (settings_load) begin
      next_s.cfg.inverse_delay_mode = set_inverse_delay_mode;
      next_s.cfg.ieee_series        = set_ieee_series;
      next_s.cfg.fixed_delay        = set_fixed_delay;
      next_s.cfg.dial               = set_dial;
      next_s.cfg.const_a            = set_const_a;
      next_s.cfg.const_b            = set_const_b;
      next_s.cfg.const_c            = set_const_c;
    end

    if (calc_done) begin
      next_s.inv_ok    = 1'b1;
      next_s.inv_delay = calc_delay;
    end

    if (tick) begin
      next_s.stamp  = s.stamp + 32'h0000_0001;
      next_s.picked = picked_now;
      case (s.state)
        ST_IDLE: begin
          if (picked_now && blk) begin
            next_s.state           = ST_BLOCKED;
            next_s.blocked_out     = 1'b1;
            next_s.event_valid     = 1'b1;
            next_s.event_magnitude = measured_magnitude;
            next_s.event_under     = under_mode;
            next_s.event_stamp     = s.stamp;
          end else if (picked_now) begin
            next_s.state     = ST_STARTED;
            next_s.start_out = 1'b1;
            next_s.elapsed   = 20'h0_0000;
            next_s.inv_ok    = 1'b0;
            if (!s.cfg.inverse_delay_mode && s.cfg.fixed_delay == 19'h0_0000) begin
              next_s.state    = ST_TRIPPED;
              next_s.trip_out = 1'b1;
            end
          end
        end
        ST_STARTED: begin
          if (blk || !picked_now) begin
            next_s.state     = ST_IDLE;
            next_s.start_out = 1'b0;
            next_s.elapsed   = 20'h0_0000;
          end else begin
            next_s.elapsed = elapsed_inc;
            if (reached) begin
              next_s.state    = ST_TRIPPED;
              next_s.trip_out = 1'b1;
            end
          end
        end
        ST_TRIPPED: begin
          if (blk || !picked_now) begin
            next_s.state     = ST_IDLE;
            next_s.start_out = 1'b0;
            next_s.trip_out  = 1'b0;
            next_s.elapsed   = 20'h0_0000;
          end
        end
        ST_BLOCKED: begin
          // Held until the pick-up element resets
          if (!picked_now) begin
            next_s.state       = ST_IDLE;
            next_s.blocked_out = 1'b0;
          end
        end
        default: begin
          next_s.state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s                        <= '0;
      s.state                  <= ST_IDLE;
      s.cfg.inverse_delay_mode <= 1'b0;
      s.cfg.ieee_series        <= 1'b0;
      s.cfg.fixed_delay        <= `FIXED_DELAY_DEF;
      s.cfg.dial               <= `DIAL_DEF;
      s.cfg.const_a            <= `CONST_A_DEF;
      s.cfg.const_b            <= `CONST_B_DEF;
      s.cfg.const_c            <= `CONST_C_DEF;
      tick_q                   <= 1'b0;
    end else begin
      s      <= next_s;
      tick_q <= tick;
    end
  end

  assign start_out          = s.start_out;
  assign trip_out           = s.trip_out;
  assign blocked_out        = s.blocked_out;
  assign inverse_delay_mode = s.cfg.inverse_delay_mode;
  assign program_tick       = tick_q;
  assign event_valid        = s.event_valid;
  assign event_magnitude    = s.event_magnitude;
  assign event_under        = s.event_under;
  assign event_stamp        = s.event_stamp;

endmodule // protection_stage_timing

/* stage_checker_assertions.sv */
`timescale 1ns/1ps

module stage_checker (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Watched inputs
  input  wire logic        block_in,
  input  wire logic        settings_load,
  input  wire logic [18:0] set_fixed_delay,
  // Watched outputs
  input  wire logic        start_out,
  input  wire logic        trip_out,
  input  wire logic        blocked_out,
  input  wire logic        inverse_delay_mode,
  input  wire logic        program_tick,
  input  wire logic        event_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic [18:0] fd;
  logic [19:0] ticks;

  // Captured delay and ticks since start
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fd    <= 19'h0_0008;
      ticks <= 20'h0_0000;
    end else begin
      if (settings_load) begin
        fd <= set_fixed_delay;
      end
      if (program_tick) begin
        ticks <= start_out ? ticks + 20'h0_0001 : 20'h0_0000;
      end
    end
  end

  a_trip_with_start: assert property (trip_out |-> start_out)
    else $error("trip without start");
  a_start_not_blocked: assert property (!(start_out && blocked_out))
    else $error("start and blocked together");
  a_block_event: assert property ($rose(blocked_out) |-> event_valid)
    else $error("blocked without event");
  a_event_one_cycle: assert property (event_valid |=> !event_valid)
    else $error("event longer than one cycle");
  a_outputs_on_tick: assert property (
    !program_tick |-> $stable({start_out, trip_out, blocked_out}))
    else $error("output changed between ticks");
  a_block_clears_start: assert property (
    program_tick && $past(block_in, 2) |-> !start_out)
    else $error("start kept while blocked");
  a_fixed_trip_time: assert property (
    program_tick && $rose(trip_out) && !inverse_delay_mode |-> ticks == {1'b0, fd})
    else $error("definite trip at wrong tick");
  a_inverse_min_time: assert property (
    program_tick && $rose(trip_out) && inverse_delay_mode
      |-> ticks >= {1'b0, fd} && ticks != 20'h0_0000)
    else $error("inverse trip before minimum");
endmodule // stage_checker

bind protection_stage_timing stage_checker stage_checker_inst (
  .ref_clk,
  .sys_rst,
  .block_in,
  .settings_load,
  .set_fixed_delay,
  .start_out,
  .trip_out,
  .blocked_out,
  .inverse_delay_mode,
  .program_tick,
  .event_valid
);

/* meas_chain_model.sv */
`timescale 1ns/1ps

module meas_chain_model (
  // Clock, reset and tick
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        program_tick,
  // Requested values
  input  wire logic [15:0] req_mag,
  input  wire logic        req_block,
  // To the stage
  output logic      [15:0] measured_magnitude,
  output logic             block_in
);
  // New values land just after a tick, well ahead of the next evaluation
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      measured_magnitude <= 16'h0000;
      block_in           <= 1'b0;
    end else if (program_tick) begin
      measured_magnitude <= req_mag;
      block_in           <= req_block;
    end
  end
endmodule // meas_chain_model

/* tb_top.sv */
`timescale 1ns/1ps
`include "prot_stage_defs.svh"

module tb_top;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] req_mag = 16'h0000;
  logic        req_block = 1'b0;
  logic [15:0] pickup_level = 16'h03E8;
  logic        under_mode = 1'b0;
  logic        settings_load = 1'b0;
  logic        set_inverse_delay_mode = 1'b0;
  logic        set_ieee_series = 1'b0;
  logic [18:0] set_fixed_delay = 19'h0_0000;
  logic [15:0] measured_magnitude;
  logic        block_in;
  logic        start_out;
  logic        trip_out;
  logic        blocked_out;
  logic        inverse_delay_mode;
  logic        program_tick;
  logic        event_valid;
  logic [15:0] event_magnitude;
  logic        event_under;
  logic [31:0] event_stamp;
  logic [2:0]  outs;
  int          mismatches = 0;
  int          n_compared = 0;

  assign outs = {start_out, trip_out, blocked_out};
  always #50 ref_clk = ~ref_clk;

  meas_chain_model meas_chain_model_inst (.ref_clk, .sys_rst, .program_tick, .req_mag,
    .req_block, .measured_magnitude, .block_in);

  protection_stage_timing #(.PROG_CYCLE_CLKS(80)) protection_stage_timing_inst (
    .ref_clk, .sys_rst, .measured_magnitude, .pickup_level, .under_mode, .block_in,
    .settings_load, .set_inverse_delay_mode, .set_ieee_series, .set_fixed_delay,
    .set_dial(`DIAL_DEF), .set_const_a(`CONST_A_DEF), .set_const_b(`CONST_B_DEF),
    .set_const_c(`CONST_C_DEF), .start_out, .trip_out, .blocked_out,
    .inverse_delay_mode, .program_tick, .event_valid, .event_magnitude, .event_under,
    .event_stamp);

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi);
    n_compared++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  // Returns just after the edge that shows a tick
  task automatic tick();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (program_tick !== 1'b1 && n < 500);
  endtask

  task automatic step(input logic [15:0] m, input logic b);
    req_mag <= m;
    req_block <= b;
    tick();
  endtask

  task automatic load(input logic i, input logic e, input logic [18:0] d);
    @(posedge ref_clk);
    settings_load <= 1'b1;
    set_inverse_delay_mode <= i;
    set_ieee_series <= e;
    set_fixed_delay <= d;
    @(posedge ref_clk);
    settings_load <= 1'b0;
    #1 chk(inverse_delay_mode, i);
    tick();
  endtask

  task automatic s_reset();
    chk({outs, inverse_delay_mode, event_valid}, 5'h00);
    tick();
  endtask

  task automatic s_definite();
    load(1'b0, 1'b0, 19'h0_0002);
    step(16'h0400, 1'b0);
    chk(outs, 3'h4);
    step(16'h03CB, 1'b0);
    chk(outs, 3'h4);
    step(16'h03CB, 1'b0);
    chk(outs, 3'h6);
    step(16'h03CA, 1'b0);
    chk(outs, 3'h0);
  endtask

  task automatic s_instant();
    load(1'b0, 1'b0, 19'h0_0000);
    step(16'h03E8, 1'b0);
    chk(outs, 3'h0);
    step(16'h0400, 1'b0);
    chk(outs, 3'h6);
    step(16'h0000, 1'b0);
    chk(outs, 3'h0);
  endtask

  task automatic s_early();
    load(1'b0, 1'b0, 19'h0_0004);
    step(16'h0400, 1'b0);
    step(16'h0400, 1'b0);
    chk(outs, 3'h4);
    step(16'h03CA, 1'b0);
    chk(outs, 3'h0);
    step(16'h03CA, 1'b0);
    chk(outs, 3'h0);
  endtask

  task automatic s_block();
    logic [31:0] stamp0;
    step(16'h0400, 1'b1);
    chk(outs, 3'h1);
    chk({event_valid, event_under, event_magnitude}, 18'h2_0400);
    stamp0 = event_stamp;
    step(16'h0400, 1'b0);
    chk(outs, 3'h1);
    step(16'h03CA, 1'b0);
    chk(outs, 3'h0);
    step(16'h0400, 1'b0);
    chk(outs, 3'h4);
    step(16'h0400, 1'b1);
    chk(outs, 3'h0);
    step(16'h0400, 1'b1);
    chk({outs, event_valid}, 4'h3);
    chk(event_stamp - stamp0, 32'h0000_0005);
    step(16'h03CA, 1'b0);
  endtask

  task automatic s_under();
    under_mode <= 1'b1;
    step(16'h03E7, 1'b0);
    chk(outs, 3'h4);
    step(16'h0405, 1'b0);
    chk(outs, 3'h4);
    step(16'h0407, 1'b0);
    chk(outs, 3'h0);
    step(16'h03E7, 1'b1);
    chk({outs, event_valid, event_under}, 5'h07);
    under_mode <= 1'b0;
    step(16'h0000, 1'b0);
    chk(outs, 3'h0);
  endtask

  task automatic run_trip(input logic e, input logic [18:0] d, output int n);
    load(1'b1, e, d);
    step(16'h07D0, 1'b0);
    chk(outs, 3'h4);
    n = 0;
    while (trip_out !== 1'b1 && n < 150) begin
      step(16'h07D0, 1'b0);
      n++;
    end
    step(16'h0000, 1'b0);
    chk(outs, 3'h0);
  endtask

  task automatic s_inverse();
    int n;
    run_trip(1'b0, 19'h0_0000, n);
    chk_rng(n, 3, 12);
    run_trip(1'b1, 19'h0_0000, n);
    chk_rng(n, 35, 85);
    run_trip(1'b0, 19'h0_0014, n);
    chk(n, 20);
    load(1'b0, 1'b1, 19'h0_0001);
    step(16'h0400, 1'b0);
    step(16'h0400, 1'b0);
    chk(outs, 3'h6);
    step(16'h0000, 1'b0);
  endtask

  initial begin
    #5_000_000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 s_reset();
    s_definite();
    s_instant();
    s_early();
    s_block();
    s_under();
    s_inverse();
    tally_and_finish();
  end
endmodule // tb_top
